// ### src/ssc_pkg.sv
// Package for the system clock synthesizer control block.
// Assumes one 10 MHz clock; the reference arrives as one-cycle edge pulses.
package ssc_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int SSC_ADDR_W = 2;
  localparam int SSC_DATA_W = 16;
  localparam logic [1:0] SSC_OFF_CTRL = 2'h0;
  localparam logic [1:0] SSC_OFF_STAT = 2'h1;
  localparam logic [1:0] SSC_OFF_MASK = 2'h2;

  // ---------------------------------------------------------------
  // Control word layout and reset value
  // ---------------------------------------------------------------
  localparam logic [15:0] SSC_CTRL_RESET = 16'h3F00;
  localparam int SSC_PRESCALE_BIT = 15;
  localparam int SSC_DIVSEL_BIT = 14;
  localparam int SSC_MOD_MSB = 13;
  localparam int SSC_MOD_LSB = 8;
  localparam int SSC_LOCK_BIT = 3;

  // Status and mask bits
  localparam int SSC_EV_GAIN = 0;
  localparam int SSC_EV_LOSS = 1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SSC_CLK_HZ = 10_000_000;
  // Oscillator credit units per oscillator tick (fvco = fref*(mod+1)*4^p/8)
  localparam logic [10:0] SSC_VCO_UNIT = 11'h0008;
  localparam logic [10:0] SSC_CREDIT_MAX = 11'h03FF;
  // Reference ticks needed to declare lock
  localparam logic [7:0] SSC_LOCK_REF_TICKS = 8'h40;
  // Reference period jitter tolerated without relock, in clk cycles
  localparam logic [11:0] SSC_REF_TOL = 12'h0002;
  localparam logic [11:0] SSC_PER_MAX = 12'hFFF;

  // Oscillator credit added per reference tick
  function automatic logic [8:0] ssc_vco_step(input logic [5:0] modulus,
                                              input logic prescale);
    logic [8:0] base;
    base = {3'b000, modulus} + 9'h001;
    ssc_vco_step = prescale ? (base << 2) : base;
  endfunction

  // Distance between two period counts
  function automatic logic [11:0] ssc_abs_diff(input logic [11:0] a, input logic [11:0] b);
    ssc_abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// ### src/ssc_lock_mon.sv
// Lock monitor of the clock synthesizer.
// Assumes relock is a pulse and ref_tick a one-cycle reference edge pulse.
`timescale 1ns/1ps
`default_nettype none
module ssc_lock_mon
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic relock,
  input wire logic ref_tick,
  // Status
  output logic locked
);

  typedef struct packed {
    logic locked;
    logic [7:0] cnt;
  } ssc_lock_state_t;

  ssc_lock_state_t q_reg, q_next;

  // ---------------------------------------------------------------
  // Lock counting
  // ---------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    if (!resetn || !enable || relock) begin
      q_next = '0;
    end else if (ref_tick && !q_reg.locked) begin
      q_next.cnt = q_reg.cnt + 8'h01;
      if (q_next.cnt == SSC_LOCK_REF_TICKS) begin
        q_next.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    q_reg <= q_next;
  end

  assign locked = q_reg.locked;

  property p_relock_clears;
    @(posedge clk) disable iff (!resetn) relock |=> !locked ##1 !locked;
  endproperty
  a_relock_clears: assert property (p_relock_clears) else $error("lock kept after relock");

endmodule
`default_nettype wire

// ### src/ssc_out_div.sv
// Output divider outside the loop: oscillator ticks to system clock enable.
// Assumes vco_tick and ref_tick are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ssc_out_div
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sources
  input wire logic vco_tick,
  input wire logic ref_tick,
  // Control
  input wire logic div_by_two,
  input wire logic bypass,
  // System clock enable
  output logic sys_clk_en
);

  typedef struct packed {
    logic [1:0] cnt;
    logic en;
  } ssc_div_state_t;

  ssc_div_state_t q_reg, q_next;

  // ---------------------------------------------------------------
  // Divide by four or two, or pass the external clock
  // ---------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    q_next.en = 1'b0;
    if (!resetn) begin
      q_next = '0;
    end else if (bypass) begin
      q_next.en = ref_tick;
      q_next.cnt = 2'b00;
    end else if (vco_tick) begin
      // divide select picks four or two
      if (div_by_two ? q_reg.cnt[0] : (q_reg.cnt == 2'b11)) begin
        q_next.en = 1'b1;
        q_next.cnt = 2'b00;
      end else begin
        q_next.cnt = q_reg.cnt + 2'b01;
      end
    end
  end

  always_ff @(posedge clk) begin
    q_reg <= q_next;
  end

  assign sys_clk_en = q_reg.en;

  property p_bypass;
    @(posedge clk) disable iff (!resetn)
      bypass && $past(bypass) && $past(resetn) |-> sys_clk_en == $past(ref_tick);
  endproperty
  a_bypass: assert property (p_bypass) else $error("external clock not passed");

endmodule
`default_nettype wire

// ### src/ssc_clock_synth.sv
// Top of the system clock synthesizer control block.
// Assumes strobes are one cycle, never together; ref_clock_input is one
// pulse per reference edge, synchronous to clk.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ssc_clock_synth
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins
  input wire logic clock_source_select_pin,
  input wire logic ref_clock_input,
  // Register port
  input wire logic [SSC_ADDR_W-1:0] addr,
  input wire logic [SSC_DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [SSC_DATA_W-1:0] rd_data,
  // Clock outputs
  output logic sys_clk_en,
  output logic synth_enabled,
  output logic synth_lock_flag,
  output logic chip_reset_n,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic mode_synth;
    logic prescale;
    logic div_sel;
    logic [5:0] modulus;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] rd_data;
    logic irq;
    logic chip_rst_n;
    logic released;
    logic [9:0] credit;
    logic vco_tick;
    logic [11:0] per_cnt;
    logic [11:0] per_last;
    logic ref_seen;
    logic ref_full;
    logic locked_d;
  } ssc_top_state_t;

  ssc_top_state_t q_reg, q_next;
  logic locked;
  logic relock_wr;
  logic relock_ref;
  logic [1:0] events;
  logic [10:0] sum;
  logic [8:0] step;
  logic ctrl_wr;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  ssc_lock_mon u_lock (
    .clk(clk),
    .resetn(resetn),
    .enable(q_reg.mode_synth),
    .relock(relock_wr | relock_ref),
    .ref_tick(ref_clock_input),
    .locked(locked)
  );

  ssc_out_div u_div (
    .clk(clk),
    .resetn(resetn),
    .vco_tick(q_reg.vco_tick),
    .ref_tick(ref_clock_input),
    .div_by_two(q_reg.div_sel),
    .bypass(!q_reg.mode_synth),
    .sys_clk_en(sys_clk_en)
  );

  // ---------------------------------------------------------------
  // Relock causes and events
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_wr = wr_en && (addr == SSC_OFF_CTRL);
    // divide select left out of the compare
    relock_wr = ctrl_wr && q_reg.mode_synth &&
                ((wr_data[SSC_PRESCALE_BIT] != q_reg.prescale) ||
                 (wr_data[SSC_MOD_MSB:SSC_MOD_LSB] != q_reg.modulus));
    // reference period moved
    // Partial first period after reset never compared
    relock_ref = q_reg.mode_synth && ref_clock_input && q_reg.ref_full &&
                 (ssc_abs_diff(q_reg.per_cnt, q_reg.per_last) > SSC_REF_TOL);
    events = 2'b00;
    events[SSC_EV_GAIN] = locked && !q_reg.locked_d;
    events[SSC_EV_LOSS] = !locked && q_reg.locked_d;
    // loop multiplier from prescale and modulus only
    step = ssc_vco_step(q_reg.modulus, q_reg.prescale);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    sum = 11'h000;
    if (!resetn) begin
      q_next = '0;
      // strap caught while reset is held
      q_next.mode_synth = clock_source_select_pin;
      q_next.prescale = SSC_CTRL_RESET[SSC_PRESCALE_BIT];
      q_next.div_sel = SSC_CTRL_RESET[SSC_DIVSEL_BIT];
      q_next.modulus = SSC_CTRL_RESET[SSC_MOD_MSB:SSC_MOD_LSB];
    end else begin
      // Register writes; lock bit has no write path
      if (ctrl_wr) begin
        q_next.prescale = wr_data[SSC_PRESCALE_BIT];
        q_next.div_sel = wr_data[SSC_DIVSEL_BIT];
        q_next.modulus = wr_data[SSC_MOD_MSB:SSC_MOD_LSB];
      end
      if (wr_en && addr == SSC_OFF_MASK) begin
        q_next.mask = wr_data[1:0];
      end
      // Sticky status, set wins over write-one clear
      if (wr_en && addr == SSC_OFF_STAT) begin
        q_next.stat = q_reg.stat & ~wr_data[1:0];
      end
      q_next.stat = q_next.stat | events;
      q_next.irq = |(q_next.stat & q_next.mask);
      q_next.locked_d = locked;
      // Read data for one cycle only
      q_next.rd_data = 16'h0000;
      if (rd_en) begin
        case (addr)
          SSC_OFF_CTRL: begin
            q_next.rd_data = {q_reg.prescale, q_reg.div_sel, q_reg.modulus, 8'h00};
            q_next.rd_data[SSC_LOCK_BIT] = locked;
          end
          SSC_OFF_STAT: q_next.rd_data = {14'h0000, q_reg.stat};
          SSC_OFF_MASK: q_next.rd_data = {14'h0000, q_reg.mask};
          default: q_next.rd_data = 16'h0000;
        endcase
      end
      q_next.vco_tick = 1'b0;
      if (q_reg.mode_synth) begin
        sum = {1'b0, q_reg.credit} + (ref_clock_input ? {2'b00, step} : 11'h000);
        // oscillator rate independent of the divide select
        if (sum >= SSC_VCO_UNIT) begin
          q_next.vco_tick = 1'b1;
          sum = sum - SSC_VCO_UNIT;
        end
        if (sum > SSC_CREDIT_MAX) begin
          sum = SSC_CREDIT_MAX;
        end
      end
      q_next.credit = sum[9:0];
      // Reference period measurement
      if (ref_clock_input) begin
        q_next.per_last = q_reg.per_cnt;
        q_next.per_cnt = 12'h001;
        q_next.ref_seen = 1'b1;
        q_next.ref_full = q_reg.ref_seen;
      end else if (q_reg.per_cnt != SSC_PER_MAX) begin
        q_next.per_cnt = q_reg.per_cnt + 12'h001;
      end
      // hold device reset until first lock when the synthesizer is selected; release at once otherwise
      q_next.chip_rst_n = !q_reg.mode_synth || locked || q_reg.released;
      q_next.released = q_reg.released || q_reg.chip_rst_n;
    end
  end

  always_ff @(posedge clk) begin
    q_reg <= q_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data = q_reg.rd_data;
  assign synth_enabled = q_reg.mode_synth;
  assign synth_lock_flag = locked;
  assign chip_reset_n = q_reg.chip_rst_n;
  assign irq = q_reg.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [3:0] h_vco;
  logic h_xchg;
  always_ff @(posedge clk) begin
    if (!resetn || sys_clk_en) begin
      h_vco <= (resetn && q_reg.vco_tick) ? 4'h1 : 4'h0;
      h_xchg <= 1'b0;
    end else begin
      h_vco <= h_vco + (q_reg.vco_tick ? 4'h1 : 4'h0);
      h_xchg <= h_xchg || ctrl_wr;
    end
  end

  property p_vco_synth;
    @(posedge clk) disable iff (!resetn) q_reg.vco_tick |-> synth_enabled;
  endproperty
  a_vco_synth: assert property (p_vco_synth) else $error("oscillator runs when disabled");

  property p_divide;
    @(posedge clk) disable iff (!resetn)
      sys_clk_en && synth_enabled && !h_xchg && !ctrl_wr |->
        h_vco == (q_reg.div_sel ? 4'h2 : 4'h4);
  endproperty
  a_divide: assert property (p_divide) else $error("wrong output divide");

  property p_reset_value;
    @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> {q_reg.prescale, q_reg.div_sel, q_reg.modulus} == SSC_CTRL_RESET[15:8];
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad control reset");

  property p_divsel_no_relock;
    @(posedge clk) disable iff (!resetn)
      ctrl_wr && locked && !relock_wr && !relock_ref |=> synth_lock_flag;
  endproperty
  a_divsel_no_relock: assert property (p_divsel_no_relock) else $error("lock lost on divide change");

  // Two cycles unlocked after a relock start
  sequence s_unlocked_pair;
    !synth_lock_flag ##1 !synth_lock_flag;
  endsequence

  property p_relock_write;
    @(posedge clk) disable iff (!resetn) relock_wr |=> s_unlocked_pair;
  endproperty
  a_relock_write: assert property (p_relock_write) else $error("no relock after write");

  property p_relock_ref;
    @(posedge clk) disable iff (!resetn) relock_ref |=> !synth_lock_flag;
  endproperty
  a_relock_ref: assert property (p_relock_ref) else $error("no relock on reference change");

  property p_lock_read;
    @(posedge clk) disable iff (!resetn)
      rd_en && addr == SSC_OFF_CTRL |=> rd_data[SSC_LOCK_BIT] == $past(locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit misread");

  property p_reset_hold;
    @(posedge clk) disable iff (!resetn)
      synth_enabled && !q_reg.released && !locked && !chip_reset_n |=> !chip_reset_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released before lock");

  property p_credit;
    @(posedge clk) disable iff (!resetn)
      synth_enabled && ref_clock_input && q_reg.credit < 10'h200 |=>
        {1'b0, q_reg.credit} + (q_reg.vco_tick ? SSC_VCO_UNIT : 11'h000) ==
        {1'b0, $past(q_reg.credit)} + {2'b00, ssc_vco_step($past(q_reg.modulus), $past(q_reg.prescale))};
  endproperty
  a_credit: assert property (p_credit) else $error("wrong loop multiplier");

  property p_hold_regs;
    @(posedge clk) disable iff (!resetn)
      !ctrl_wr |=> $stable({q_reg.prescale, q_reg.div_sel, q_reg.modulus});
  endproperty
  a_hold_regs: assert property (p_hold_regs) else $error("control changed without write");

  // Events land in status even beside a clear
  property p_stat_set;
    @(posedge clk) disable iff (!resetn)
      |events |=> (q_reg.stat & $past(events)) == $past(events);
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status event lost");

  // Read data only in the cycle after the strobe
  property p_rd_idle;
    @(posedge clk) disable iff (!resetn) !rd_en |=> rd_data == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  // No lock shown with the synthesizer off
  property p_ext_unlocked;
    @(posedge clk) disable iff (!resetn) !synth_enabled |-> !synth_lock_flag;
  endproperty
  a_ext_unlocked: assert property (p_ext_unlocked) else $error("lock shown without synthesizer");

endmodule
`default_nettype wire

// ### bench/ssc_clock_synth_tb.sv
// Testbench for the system clock synthesizer control block.
// Assumes one 10 MHz clk; the bench makes reference pulses on that clock.
`timescale 1ns/1ps
`default_nettype none
module ssc_clock_synth_tb;
  import ssc_pkg::*;

  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic strap = 1'h1;
  logic ref_pulse = 1'h0;
  logic ref_on = 1'h1;
  logic [SSC_ADDR_W-1:0] addr = '0;
  logic [SSC_DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic [SSC_DATA_W-1:0] rd_data;
  logic sys_clk_en;
  logic synth_enabled;
  logic synth_lock_flag;
  logic chip_reset_n;
  logic irq;
  int n_mismatch = 0;
  int checks_done = 0;
  int ref_per = 10;
  int ref_cnt = 0;
  int n_sys = 0;
  int t;

  // 10 MHz clock
  always #50 clk = ~clk;

  ssc_clock_synth ssc_clock_synth_i (
    .clk(clk),
    .resetn(resetn),
    .clock_source_select_pin(strap),
    .ref_clock_input(ref_pulse),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .sys_clk_en(sys_clk_en),
    .synth_enabled(synth_enabled),
    .synth_lock_flag(synth_lock_flag),
    .chip_reset_n(chip_reset_n),
    .irq(irq)
  );

  // Reference pulse train, one cycle every ref_per cycles
  always @(posedge clk) begin
    if (!ref_on || ref_cnt >= ref_per - 1) begin
      ref_pulse <= ref_on;
      ref_cnt <= 0;
    end else begin
      ref_pulse <= 1'h0;
      ref_cnt <= ref_cnt + 1;
    end
  end

  // Count system clock enables
  always @(posedge clk) begin
    if (sys_clk_en === 1'h1) begin
      n_sys <= n_sys + 1;
    end
  end

  // ---------------------------------------------------------------
  // Compare, bus and wait tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  // Read data is sampled in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    @(negedge clk);
    check_word(rd_data, exp);
  endtask

  // Cycles until lock, bounded, sampled between edges
  task automatic wait_lock(input int lo, input int hi);
    int n;
    n = 0;
    @(negedge clk);
    while (synth_lock_flag !== 1'h1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      close_out();
    end else begin
      check_range(n, lo, hi);
    end
  endtask

  // Enables seen over a window, two of slack for edge effects
  task automatic measure(input int cyc, input int exp);
    int s;
    s = n_sys;
    repeat (cyc) @(negedge clk);
    check_range(n_sys - s, exp - 2, exp + 2);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    resetn <= 1'h0;
    strap <= s;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    @(negedge clk);
  endtask

  task automatic settle();
    @(negedge clk);
    @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'h1);
    check_bit(synth_enabled, 1'h1); // synthesizer selected
    check_bit(chip_reset_n, 1'h0); // held before lock
    reg_rd(SSC_OFF_CTRL, 16'h3F00); // reset value
    reg_rd(SSC_OFF_MASK, 16'h0000);
    wait_lock(600, 660); // lock after reference count
    settle();
    check_bit(chip_reset_n, 1'h1); // released after lock
    reg_rd(SSC_OFF_CTRL, 16'h3F08); // lock bit set
    check_bit(irq, 1'h0);
    reg_rd(SSC_OFF_STAT, 16'h0001);
    reg_wr(SSC_OFF_MASK, 16'h0001);
    settle();
    check_bit(irq, 1'h1);
    reg_wr(SSC_OFF_STAT, 16'h0001);
    settle();
    check_bit(irq, 1'h0);
    reg_rd(SSC_OFF_STAT, 16'h0000);
    reg_wr(2'h3, 16'hFFFF);
    reg_rd(2'h3, 16'h0000);
    measure(320, 64); // default rate twice reference
    reg_wr(SSC_OFF_CTRL, 16'h7F00); // rate within limits
    settle();
    check_bit(synth_lock_flag, 1'h1); // no relock on divide select
    measure(320, 128); // divide by two
    reg_wr(SSC_OFF_CTRL, 16'h1F00);
    @(negedge clk);
    check_bit(synth_lock_flag, 1'h0); // relock starts
    reg_wr(SSC_OFF_CTRL, 16'h1F0F);
    reg_rd(SSC_OFF_CTRL, 16'h1F00); // lock bit read-only
    reg_rd(SSC_OFF_STAT, 16'h0002);
    wait_lock(580, 660); // relock interval
    measure(320, 32); // modulus 31
    reg_wr(SSC_OFF_CTRL, 16'hC700);
    wait_lock(580, 660); // prescale change relocks
    measure(320, 64); // prescale and divide select
    reg_rd(SSC_OFF_MASK, 16'h0001); // contents kept across rate change
    ref_per = 20;
    t = 0;
    while (synth_lock_flag === 1'h1 && t < 60) begin
      @(negedge clk);
      t++;
    end
    check_range(t, 1, 45); // reference change relocks
    check_bit(chip_reset_n, 1'h1); // power-up only
    wait_lock(1200, 1330); // relock on new reference
    settle();
    check_bit(irq, 1'h1);
    ref_per = 10;
    do_reset(1'h0);
    check_bit(synth_enabled, 1'h0); // synthesizer off
    settle();
    check_bit(chip_reset_n, 1'h1); // no lock wait
    reg_rd(SSC_OFF_CTRL, 16'h3F00); // lock bit clear
    measure(320, 32); // reference is the system clock
    check_bit(synth_lock_flag, 1'h0); // no lock report
    ref_on <= 1'h0;
    measure(100, 0); // no external clock, no enables
    close_out();
  end

  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

endmodule
`default_nettype wire
